// [srcp_pkg.sv]
// package for the serial register control port: constants shared by both ends
`default_nettype none
package srcp_pkg;
   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int SRCP_BYTE_BITS = 8;
   localparam int SRCP_INDEX_BITS = 7;
   localparam int SRCP_CMD_DIR_BIT = 0;
   localparam logic SRCP_DIR_WRITE = 1'b0;
   localparam logic SRCP_DIR_READ = 1'b1;
   localparam logic [6:0] SRCP_LAST_INDEX = 7'h7f;
   localparam logic [6:0] SRCP_PAGE_CTRL_INDEX = 7'h00;
   localparam logic [7:0] SRCP_PAGE_RESET = 8'h00;
   localparam int SRCP_NUM_PAGES = 2;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SRCP_SYS_PERIOD_NS = 40;
   localparam int SRCP_CS_GAP_NS = 6250;
   localparam int SRCP_CS_GAP_CYC = (SRCP_CS_GAP_NS + SRCP_SYS_PERIOD_NS - 1) / SRCP_SYS_PERIOD_NS;
   // two flops each way plus the output register put miso five clocks behind a rise,
   // so a half period of eight leaves margin before the host samples on the fall
   localparam int SRCP_SCLK_HALF_CYC = 8;
   // host command kinds
   typedef enum logic [1:0] {
      SRCP_OP_WRITE = 2'h0,
      SRCP_OP_READ = 2'h1
   } srcp_op_t;
endpackage
`default_nettype wire

// [srcp_if.sv]
// interface joining the host master and the device slave of the control port
`default_nettype none
interface srcp_if;
   logic shared_pin_0; // chip_select_n
   logic shared_pin_1; // serial clock
   logic shared_pin_2; // miso
   logic shared_pin_3; // mosi
   modport host (output shared_pin_0, output shared_pin_1, output shared_pin_3,
      input shared_pin_2);
   modport device (input shared_pin_0, input shared_pin_1, input shared_pin_3,
      output shared_pin_2);
endinterface
`default_nettype wire

// [srcp_device.sv]
// device end: spi slave giving access to paged 8-bit control registers
// What this block does
// - strap high selects spi, low leaves the pins unused
// - strap stays fixed during operation
// - pins: cs_n, clock, miso, mosi; cpol 0
// - clock phase 1: drive on first edge
// - full duplex shifting in and out
// - first 8 bits after cs fall command
// - command: index bits 7..1, direction bit 0
// - direction 0 writes next byte to register
// - direction 1 returns register on second byte
// - host writes reserved bits with defaults
// - continuous write goes to next index
// - continuous read returns following registers
// - cs rise ends frame and burst
// - burst stops at last index of page
// - index 0 selects page, page 0 at reset
// - registers are 8 bits, d7 msb
`default_nettype none
module srcp_device
   import srcp_pkg::*;
#(
   parameter int PAGES = SRCP_NUM_PAGES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic protocol_pick,
   srcp_if.device link,
   output logic spi_active,
   output logic miso_oe,
   output logic [7:0] page,
   output logic wr_strobe,
   output logic [6:0] wr_index,
   output logic [7:0] wr_data
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] cs_s, ck_s, mo_s;
   logic cs_q, ck_q;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cs_s <= 2'h3;
         ck_s <= 2'h0;
         mo_s <= 2'h0;
         cs_q <= 1'b1;
         ck_q <= 1'b0;
      end else begin
         cs_s <= {cs_s[0], link.shared_pin_0};
         ck_s <= {ck_s[0], link.shared_pin_1};
         mo_s <= {mo_s[0], link.shared_pin_3};
         cs_q <= cs_s[1];
         ck_q <= ck_s[1];
      end
   end
   // ----------------------------------------------------------------
   // strap and edge detection
   // ----------------------------------------------------------------
   // the strap is meant to stay put; a change inside a frame is not guarded
   // strap: pins act as spi only while the strap is high
   logic [1:0] sel_s;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sel_s <= 2'h0;
      end else begin
         sel_s <= {sel_s[0], protocol_pick};
      end
   end
   assign spi_active = sel_s[1];
   // edges come from the synchronised copy and the flop behind it
   logic cs_fall, cs_rise, ck_rise, ck_fall, in_frame;
   assign cs_fall = spi_active && cs_q && !cs_s[1];
   assign cs_rise = !cs_q && cs_s[1];
   assign in_frame = spi_active && !cs_s[1] && !cs_q;
   assign ck_rise = in_frame && !ck_q && ck_s[1];
   assign ck_fall = in_frame && ck_q && !ck_s[1];
   // ----------------------------------------------------------------
   // register storage: flip-flops indexed by page and index
   // ----------------------------------------------------------------
   logic [7:0] regs [PAGES][128];
   logic [7:0] shift_in, shift_out;
   logic [2:0] bit_cnt;
   logic have_cmd, dir_read;
   logic [6:0] index;
   logic at_end; // burst reached the page end
   logic [7:0] byte_in;
   logic byte_done;
   assign byte_in = {shift_in[6:0], mo_s[1]};
   assign byte_done = ck_fall && (bit_cnt == 3'h7);
   // read mux shared by the command load and the burst load; unbacked pages read 0 except index 0, which returns the page
   function automatic logic [7:0] read_reg(input logic [7:0] pg, input logic [6:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx == SRCP_PAGE_CTRL_INDEX) begin
         v = pg;
      end else if (pg < 8'(PAGES)) begin
         v = regs[pg[0]][idx];
      end
      return v;
   endfunction
   // ----------------------------------------------------------------
   // bit counting and shifting
   // ----------------------------------------------------------------
   // mosi is captured on falling clock edges
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shift_in <= 8'h00;
         bit_cnt <= 3'h0;
      end else if (cs_fall || cs_rise) begin
         bit_cnt <= 3'h0; // either cs edge restarts the bit count
      end else if (ck_fall) begin
         shift_in <= byte_in;
         bit_cnt <= bit_cnt + 3'h1;
      end
   end
   // command decode and index stepping
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         have_cmd <= 1'b0;
         dir_read <= 1'b0;
         index <= 7'h00;
         at_end <= 1'b0;
      end else if (cs_fall || cs_rise) begin
         have_cmd <= 1'b0;
         at_end <= 1'b0;
      end else if (byte_done) begin
         if (!have_cmd) begin
            have_cmd <= 1'b1;
            index <= byte_in[7:1];
            dir_read <= byte_in[SRCP_CMD_DIR_BIT];
         end else if (index == SRCP_LAST_INDEX) begin
            at_end <= 1'b1; // no wrap past the page
         end else begin
            index <= index + 7'h1;
         end
      end
   end
   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // writes, including the page control register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         page <= SRCP_PAGE_RESET;
         wr_strobe <= 1'b0;
         wr_index <= 7'h00;
         wr_data <= 8'h00;
         for (int p = 0; p < PAGES; p++) begin
            for (int i = 0; i < 128; i++) begin
               regs[p][i] <= 8'h00;
            end
         end
      end else begin
         wr_strobe <= 1'b0;
         if (byte_done && have_cmd && !dir_read && !at_end) begin
            wr_strobe <= 1'b1;
            wr_index <= index;
            wr_data <= byte_in;
            if (index == SRCP_PAGE_CTRL_INDEX) begin
               page <= byte_in;
            end else if (page < 8'(PAGES)) begin
               regs[page[0]][index] <= byte_in;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // miso shifting
   // ----------------------------------------------------------------
   // miso: cleared at frame start, loaded at the end of each byte, shifted on rising clock edges
   // limitation: miso moves three clocks after the pin rises, so the master
   // needs a half period well above that before it samples on the fall
   // loading at the end of each byte leaves a whole low phase before the next rise
   logic [7:0] next_load;
   logic load_now;
   always_comb begin
      next_load = 8'h00;
      load_now = 1'b0;
      if (byte_done) begin
         load_now = 1'b1;
         if (!have_cmd && byte_in[SRCP_CMD_DIR_BIT] == SRCP_DIR_READ) begin
            next_load = read_reg(page, byte_in[7:1]);
         end else if (have_cmd && dir_read && index != SRCP_LAST_INDEX) begin
            next_load = read_reg(page, index + 7'h1);
         end
      end
   end
   // miso cleared at both select edges so nothing stale leaks into a frame
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shift_out <= 8'h00;
         link.shared_pin_2 <= 1'b0;
      end else if (cs_fall || cs_rise) begin
         shift_out <= 8'h00;
         link.shared_pin_2 <= 1'b0;
      end else begin
         if (load_now) begin
            shift_out <= next_load;
         end else if (ck_rise) begin
            link.shared_pin_2 <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end
   assign miso_oe = in_frame;
endmodule // srcp_device
`default_nettype wire

// [srcp_host.sv]
// host end: spi master issuing single or burst register frames
`default_nettype none
module srcp_host
   import srcp_pkg::*;
#(
   parameter int HALF_CYC = SRCP_SCLK_HALF_CYC,
   parameter int GAP_CYC = SRCP_CS_GAP_CYC,
   parameter int MAX_BYTES = 4
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   srcp_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire srcp_op_t req_op,
   input wire logic [6:0] req_index,
   input wire logic [2:0] req_count,
   input wire logic [7:0] wr_byte,
   output logic wr_byte_take,
   output logic [7:0] rd_byte,
   output logic rd_byte_valid,
   output logic busy
);
   typedef enum logic [3:0] {
      SRCP_H_IDLE = 4'b0001,
      SRCP_H_LOW = 4'b0010,
      SRCP_H_HIGH = 4'b0100,
      SRCP_H_GAP = 4'b1000
   } srcp_hstate_t;
   srcp_hstate_t state;
   logic [7:0] tx, rx;
   logic [2:0] bit_cnt, left;
   logic [15:0] tmr;
   logic is_read, cmd_phase;
   logic mi_s0, mi_s1;
   assign req_ready = (state == SRCP_H_IDLE);
   assign busy = (state != SRCP_H_IDLE);
   // ----------------------------------------------------------------
   // miso synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         mi_s0 <= 1'b0;
         mi_s1 <= 1'b0;
      end else begin
         mi_s0 <= link.shared_pin_2;
         mi_s1 <= mi_s0;
      end
   end
   // frame sequencer: clock idles low, data driven on rise, sampled on fall
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= SRCP_H_IDLE;
         link.shared_pin_0 <= 1'b1;
         link.shared_pin_1 <= 1'b0;
         link.shared_pin_3 <= 1'b0;
         tx <= 8'h00;
         rx <= 8'h00;
         bit_cnt <= 3'h0;
         left <= 3'h0;
         tmr <= 16'h0000;
         is_read <= 1'b0;
         cmd_phase <= 1'b0;
         rd_byte <= 8'h00;
         rd_byte_valid <= 1'b0;
         wr_byte_take <= 1'b0;
      end else begin
         rd_byte_valid <= 1'b0;
         wr_byte_take <= 1'b0;
         unique case (state)
            SRCP_H_IDLE: begin
               if (req_valid) begin
                  tx <= {req_index, (req_op == SRCP_OP_READ)};
                  is_read <= (req_op == SRCP_OP_READ);
                  left <= (req_count == 3'h0) ? 3'h1 : req_count;
                  cmd_phase <= 1'b1;
                  bit_cnt <= 3'h0;
                  tmr <= 16'h0000;
                  link.shared_pin_0 <= 1'b0; // new frame, new command
                  state <= SRCP_H_LOW;
               end
            end
            SRCP_H_LOW: begin
               if (tmr == 16'(HALF_CYC - 1)) begin
                  tmr <= 16'h0000;
                  link.shared_pin_1 <= 1'b1;
                  link.shared_pin_3 <= tx[7];
                  tx <= {tx[6:0], 1'b0};
                  state <= SRCP_H_HIGH;
               end else begin
                  tmr <= tmr + 16'h1;
               end
            end
            SRCP_H_HIGH: begin
               if (tmr == 16'(HALF_CYC - 1)) begin
                  tmr <= 16'h0000;
                  link.shared_pin_1 <= 1'b0;
                  rx <= {rx[6:0], mi_s1};
                  bit_cnt <= bit_cnt + 3'h1;
                  state <= SRCP_H_LOW;
                  if (bit_cnt == 3'h7) begin
                     if (!cmd_phase && is_read) begin
                        rd_byte <= {rx[6:0], mi_s1};
                        rd_byte_valid <= 1'b1;
                     end
                     if (!cmd_phase) begin
                        left <= left - 3'h1;
                     end
                     if (!cmd_phase && left == 3'h1) begin
                        state <= SRCP_H_GAP;
                     end else begin
                        tx <= is_read ? 8'h00 : wr_byte;
                        wr_byte_take <= !is_read;
                     end
                     cmd_phase <= 1'b0;
                  end
               end else begin
                  tmr <= tmr + 16'h1;
               end
            end
            SRCP_H_GAP: begin
               link.shared_pin_0 <= 1'b1;
               // cs stays high long enough between writes
               if (tmr == 16'(GAP_CYC)) begin
                  tmr <= 16'h0000;
                  state <= SRCP_H_IDLE;
               end else begin
                  tmr <= tmr + 16'h1;
               end
            end
         endcase
      end
   end
   // burst length is not clipped to the page; the device drops bytes past the last index
   logic unused_max;
   assign unused_max = (MAX_BYTES > 0);
endmodule // srcp_host
`default_nettype wire

// [srcp_link_props.sv]
// checker of the control port link: wire rules seen between host and device
`default_nettype none
module srcp_link_props
   import srcp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic shared_pin_0,
   input wire logic shared_pin_1,
   input wire logic shared_pin_2,
   input wire logic shared_pin_3
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk_q;
   logic [7:0] rise_cnt;
   logic [15:0] cs_high_cnt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   // clock rises counted per frame, so a short or long byte shows at select rise
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sclk_q <= 1'b0;
         rise_cnt <= 8'h00;
      end else begin
         sclk_q <= shared_pin_1;
         if ($fell(shared_pin_0)) begin
            rise_cnt <= 8'h00;
         end else if (shared_pin_1 && !sclk_q) begin
            rise_cnt <= rise_cnt + 8'h01;
         end
      end
   end
   // cycles of select high before each frame, saturating so reset counts as a long gap
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cs_high_cnt <= 16'hffff;
      end else if (!shared_pin_0) begin
         cs_high_cnt <= 16'h0000;
      end else if (cs_high_cnt != 16'hffff) begin
         cs_high_cnt <= cs_high_cnt + 16'h0001;
      end
   end
   // ----------------------------------------------------------------
   // sequences and assertions
   // ----------------------------------------------------------------
   // half period of eight system clocks, the bench runs the host at that rate
   sequence s_high_half;
      shared_pin_1[*8] ##1 !shared_pin_1;
   endsequence
   sequence s_cs_quiet;
      shared_pin_0[*5];
   endsequence
   sequence s_cs_gap;
      shared_pin_0[*4];
   endsequence
   chk_sclk_idle_low: assert property (shared_pin_0 |-> !shared_pin_1)
      else $error("serial clock high outside a frame");
   chk_frame_start_low: assert property ($fell(shared_pin_0) |-> !shared_pin_1)
      else $error("frame opened with clock high");
   chk_first_edge_soon: assert property ($fell(shared_pin_0) |-> ##[1:12] $rose(shared_pin_1))
      else $error("first clock edge late");
   chk_sclk_high_time: assert property ($rose(shared_pin_1) |-> s_high_half)
      else $error("clock high phase wrong length");
   chk_mosi_held_high: assert property (shared_pin_1 && $past(shared_pin_1) |-> $stable(shared_pin_3))
      else $error("mosi moved while clock high");
   chk_miso_quiet_idle: assert property (s_cs_quiet |-> !shared_pin_2)
      else $error("miso not cleared between frames");
   chk_frame_whole_bytes: assert property ($rose(shared_pin_0) |-> rise_cnt[2:0] == 3'h0 && rise_cnt >= 8'h10)
      else $error("frame not whole command and data bytes");
   chk_cs_gap_held: assert property ($rose(shared_pin_0) |-> s_cs_gap)
      else $error("select gap too short");
   chk_cs_gap_long: assert property ($fell(shared_pin_0) |-> cs_high_cnt >= 16'(SRCP_CS_GAP_CYC))
      else $error("select high shorter than the write gap");
   chk_miso_on_rise: assert property (!shared_pin_0 && $changed(shared_pin_2) |-> shared_pin_1)
      else $error("miso moved while clock low");
   chk_mosi_on_rise: assert property ($changed(shared_pin_3) |-> $rose(shared_pin_1))
      else $error("mosi moved away from a rising clock");
endmodule // srcp_link_props
`default_nettype wire

// [spi_register_control_port_bench.sv]
// bench for the control port: host and device joined over one link
`default_nettype none
module spi_register_control_port_bench import srcp_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic protocol_pick = 1'b1;
   logic req_valid = 1'b0;
   srcp_op_t req_op = SRCP_OP_WRITE;
   logic [6:0] req_index = 7'h00;
   logic [2:0] req_count = 3'h1;
   logic [7:0] wr_byte = 8'h00;
   logic req_ready, wr_byte_take, rd_byte_valid, busy, spi_active, miso_oe, wr_strobe;
   logic [7:0] rd_byte, page, wr_data;
   logic [6:0] wr_index;
   int error_cnt = 0;
   int compares = 0;
   int oe_cycles = 0;
   logic [14:0] wq[$];
   logic [7:0] rq[$];
   logic [7:0] tx[4];
   srcp_if link_if();
   srcp_device srcp_device_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .protocol_pick(protocol_pick), .link(link_if), .spi_active(spi_active),
      .miso_oe(miso_oe), .page(page), .wr_strobe(wr_strobe), .wr_index(wr_index),
      .wr_data(wr_data));
   // host runs at the package rates so the checker sees the full select gap
   srcp_host #(.HALF_CYC(SRCP_SCLK_HALF_CYC), .GAP_CYC(SRCP_CS_GAP_CYC), .MAX_BYTES(4))
      srcp_host_i (.clk_sys(clk_sys),
      .reset_n(reset_n), .link(link_if), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_index(req_index), .req_count(req_count), .wr_byte(wr_byte),
      .wr_byte_take(wr_byte_take), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
      .busy(busy));
   srcp_link_props srcp_link_props_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .shared_pin_0(link_if.shared_pin_0), .shared_pin_1(link_if.shared_pin_1),
      .shared_pin_2(link_if.shared_pin_2), .shared_pin_3(link_if.shared_pin_3));
   always #20 clk_sys = ~clk_sys;
   // strobes and read bytes are queued so no one-cycle pulse is missed
   always @(posedge clk_sys) begin
      if (wr_strobe === 1'b1) wq.push_back({wr_index, wr_data});
      if (rd_byte_valid === 1'b1) rq.push_back(rd_byte);
      if (miso_oe === 1'b1) oe_cycles++;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         error_cnt++;
      end
   endtask
   task automatic pop_wr(input logic [6:0] i, input logic [7:0] d);
      check("write", (wq.size() > 0) ? {1'b0, wq.pop_front()} : 16'hffff, {1'b0, i, d});
   endtask
   task automatic pop_rd(input logic [7:0] d);
      check("read", (rq.size() > 0) ? {8'h00, rq.pop_front()} : 16'hffff, {8'h00, d});
   endtask
   // one host request; next byte offered only after the take cycle has passed
   task automatic xfer(input srcp_op_t op, input logic [6:0] idx, input logic [2:0] cnt);
      int k;
      int n;
      logic took;
      k = 0;
      n = 0;
      took = 1'b0;
      wr_byte = tx[0];
      while (req_ready !== 1'b1 && n < 500) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      req_op = op;
      req_index = idx;
      req_count = cnt;
      req_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      n = 0;
      while ((busy === 1'b1 || req_ready !== 1'b1) && n < 3000) begin
         if (took && k < 3) k++;
         took = (wr_byte_take === 1'b1);
         wr_byte = tx[k];
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 3000) check("request done", 16'h0000, 16'h0001);
   endtask
   task automatic final_report;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_single;
      check("reset page", {8'h00, page}, {8'h00, SRCP_PAGE_RESET});
      check("spi on", {15'h0, spi_active}, 16'h0001);
      tx = '{8'ha5, 8'h00, 8'h00, 8'h00};
      xfer(SRCP_OP_WRITE, 7'h05, 3'h1);
      pop_wr(7'h05, 8'ha5);
      tx[0] = 8'h81;
      xfer(SRCP_OP_WRITE, 7'h6a, 3'h1);
      pop_wr(7'h6a, 8'h81);
      xfer(SRCP_OP_READ, 7'h6a, 3'h1);
      pop_rd(8'h81);
      xfer(SRCP_OP_READ, 7'h05, 3'h1);
      pop_rd(8'ha5);
      check("no write on read", 16'(wq.size()), 16'h0000);
      check("oe in frame", {15'h0, oe_cycles > 0}, 16'h0001);
   endtask
   // bursts, one ending on the last index where the extra byte must vanish
   task automatic t_burst;
      tx = '{8'h11, 8'h22, 8'h33, 8'h00};
      xfer(SRCP_OP_WRITE, 7'h10, 3'h3);
      pop_wr(7'h10, 8'h11);
      pop_wr(7'h11, 8'h22);
      pop_wr(7'h12, 8'h33);
      xfer(SRCP_OP_READ, 7'h10, 3'h3);
      pop_rd(8'h11);
      pop_rd(8'h22);
      pop_rd(8'h33);
      tx = '{8'h44, 8'h55, 8'h66, 8'h00};
      xfer(SRCP_OP_WRITE, SRCP_LAST_INDEX - 7'h01, 3'h3);
      pop_wr(SRCP_LAST_INDEX - 7'h01, 8'h44);
      pop_wr(SRCP_LAST_INDEX, 8'h55);
      check("no wrap", 16'(wq.size()), 16'h0000);
      xfer(SRCP_OP_READ, SRCP_LAST_INDEX - 7'h01, 3'h2);
      pop_rd(8'h44);
      pop_rd(8'h55);
   endtask
   task automatic t_page;
      tx[0] = 8'h01;
      xfer(SRCP_OP_WRITE, SRCP_PAGE_CTRL_INDEX, 3'h1);
      check("page one", {8'h00, page}, 16'h0001);
      tx[0] = 8'h3c;
      xfer(SRCP_OP_WRITE, 7'h05, 3'h1);
      xfer(SRCP_OP_READ, 7'h05, 3'h1);
      xfer(SRCP_OP_READ, SRCP_PAGE_CTRL_INDEX, 3'h1);
      tx[0] = 8'h00;
      xfer(SRCP_OP_WRITE, SRCP_PAGE_CTRL_INDEX, 3'h1);
      xfer(SRCP_OP_READ, 7'h05, 3'h1);
      pop_rd(8'h3c);
      pop_rd(8'h01);
      pop_rd(8'ha5);
      check("page zero", {8'h00, page}, 16'h0000);
   endtask
   // strap moved only between frames, never during one
   task automatic t_strap;
      int oe_seen;
      wq.delete();
      protocol_pick = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      check("spi off", {15'h0, spi_active}, 16'h0000);
      tx[0] = 8'hff;
      oe_seen = oe_cycles;
      xfer(SRCP_OP_WRITE, 7'h05, 3'h1);
      check("ignored write", 16'(wq.size()), 16'h0000);
      check("oe strap off", 16'(oe_cycles - oe_seen), 16'h0000);
      protocol_pick = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      rq.delete();
      xfer(SRCP_OP_READ, 7'h05, 3'h1);
      pop_rd(8'ha5);
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      t_single();
      t_burst();
      t_page();
      t_strap();
      final_report();
   end
   // the tests need about a third of this span at the full select gap
   initial begin
      #1ms;
      error_cnt++;
      final_report();
   end
endmodule // spi_register_control_port_bench
`default_nettype wire
